// *** pkg/demod_ctrl_defs.vh ***
`ifndef DEMOD_CTRL_DEFS_VH
`define DEMOD_CTRL_DEFS_VH
// ---------------------------------------------------------------
// Register addresses
// ---------------------------------------------------------------
`define ADDR_GENERAL_RESET     8'h1a
`define ADDR_GENERAL_CONTROL   8'h1b
`define ADDR_GAIN_DRIVE        8'h1c
`define ADDR_CHANNEL_LO        8'h1d
`define ADDR_DC_OFFSET         8'h1f
`define ADDR_INTERMOD          8'h2f
// ---------------------------------------------------------------
// Reset and forced values
// ---------------------------------------------------------------
`define REG_RESET              8'h00
`define GC_FORCED_BASE         8'h12
`define GC_DIV2_BIT            7
`define GD_GAIN_REDUCED        8'h09
`define GD_GAIN_MAX            8'h00
`define CL_FORCED              8'h0f
`define IM_FORCED              8'h00
`define OFFSET_STEP_MV         60
`endif

// *** hw/offset_decode.v ***
// ---------------------------------------------------------------
// Sign-magnitude offset code to signed millivolts
// ---------------------------------------------------------------
module offset_decode (
  input  wire [3:0]  code,
  output reg  [9:0]  milliVolts
);
  reg [9:0] mag;
  always @* begin
    mag = 10'h000;
    mag = code[2:0] * 10'h03c;
    // Both 4'h0 and 4'h8 land at zero, negative zero is no correction
    milliVolts = code[3] ? (10'h000 - mag) : mag;
  end
endmodule // offset_decode

// *** hw/demod_control_registers.v ***
// Function
// - Offset register: upper nibble Q dc correction, lower nibble I correction.
// - Offset codes are sign-magnitude in 60mV steps; 0000 and 1000 mean none.
// - Intermod register holds a six-bit mixer tuning field in bits 7..2.
// - General reset command clears offset and intermod registers.
// - Low bus-disable pin selects direct control; serial pins get new roles.
// - Direct reset low forces registers to zero and low-power mode.
// - Direct reset high leaves low power; divider and gain pins act.
// - Gain select high gives max gain; low loads 0,1,0,0,1.
// - Direct control: bias and receiver enable set, bit 7 is the inverted divider pin, other control bits zero.
// - Direct control: channel and reserved bits zero, LO tuning all ones.
// - Direct control: offset and intermod registers all zero.
// - Reset command and power-on reset clear everything into powersave.
// - A transaction is one address byte then zero or one data byte.
// - Serial data is sampled on the serial clock rising edge.
`include "demod_ctrl_defs.vh"
module demod_control_registers (
  input  wire        clk,
  input  wire        rst,
  input  wire        serial_disable_n,
  input  wire        serial_command_in,
  input  wire        sclk,
  input  wire        serial_select_n,
  output reg  [7:0]  generalControl_r,
  output reg  [7:0]  gainDriveControl_r,
  output reg  [7:0]  channelLoTuning_r,
  output reg  [7:0]  dcOffsetCorrection_r,
  output reg  [7:0]  intermodTuning_r,
  output reg         lowPower_r,
  output reg  [9:0]  qOffsetMv_r,
  output reg  [9:0]  iOffsetMv_r
);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  reg [1:0] disSync_r;
  reg [1:0] dataSync_r;
  reg [1:0] clkSync_r;
  reg [1:0] selSync_r;
  reg       clkPrev_r;
  always @(posedge clk) begin
    if (rst) begin
      disSync_r  <= 2'h3;
      dataSync_r <= 2'h0;
      clkSync_r  <= 2'h0;
      selSync_r  <= 2'h3;
      clkPrev_r  <= 1'b0;
    end else begin
      disSync_r  <= {disSync_r[0], serial_disable_n};
      dataSync_r <= {dataSync_r[0], serial_command_in};
      clkSync_r  <= {clkSync_r[0], sclk};
      selSync_r  <= {selSync_r[0], serial_select_n};
      clkPrev_r  <= clkSync_r[1];
    end
  end
  wire directMode      = ~disSync_r[1];
  wire direct_reset_n  = dataSync_r[1];
  wire lo_divider_select = clkSync_r[1];
  wire gainSelect      = selSync_r[1];
  wire sclkRise        = clkSync_r[1] & ~clkPrev_r;
  wire selActive       = ~selSync_r[1];

  // ---------------------------------------------------------------
  // Serial receiver
  // ---------------------------------------------------------------
  // Limitation: sclk must be well below clk/4 since it is oversampled
  reg [7:0] shift_r;
  reg [2:0] bitCnt_r;
  reg       haveAddr_r;
  reg       dataDone_r;
  reg [7:0] addr_r;
  reg       byteDone_r;
  always @(posedge clk) begin
    if (rst || !selActive || directMode) begin
      bitCnt_r   <= 3'h0;
      haveAddr_r <= 1'b0;
      dataDone_r <= 1'b0;
      byteDone_r <= 1'b0;
      shift_r    <= 8'h00;
      addr_r     <= 8'h00;
    end else begin
      byteDone_r <= 1'b0;
      if (sclkRise && !dataDone_r) begin
        shift_r  <= {shift_r[6:0], dataSync_r[1]};
        bitCnt_r <= bitCnt_r + 3'h1;
        if (bitCnt_r == 3'h7) begin
          byteDone_r <= 1'b1;
        end
      end
      if (byteDone_r) begin
        if (!haveAddr_r) begin
          addr_r     <= shift_r;
          haveAddr_r <= 1'b1;
        end else begin
          dataDone_r <= 1'b1;
        end
      end
    end
  end
  wire addrStrobe = byteDone_r & ~haveAddr_r & ~directMode;
  wire dataStrobe = byteDone_r & haveAddr_r & ~dataDone_r & ~directMode;
  wire genReset   = addrStrobe && (shift_r == `ADDR_GENERAL_RESET);

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  reg [7:0] gcNxt;
  reg [7:0] gdNxt;
  always @* begin
    gcNxt = `GC_FORCED_BASE;
    gcNxt[`GC_DIV2_BIT] = ~lo_divider_select;
    gdNxt = gainSelect ? `GD_GAIN_MAX : `GD_GAIN_REDUCED;
  end
  always @(posedge clk) begin
    if (rst || genReset) begin
      generalControl_r     <= `REG_RESET;
      gainDriveControl_r   <= `REG_RESET;
      channelLoTuning_r    <= `REG_RESET;
      dcOffsetCorrection_r <= `REG_RESET;
      intermodTuning_r     <= `REG_RESET;
      lowPower_r           <= 1'b1;
    end else if (directMode) begin
      if (!direct_reset_n) begin
        generalControl_r     <= `REG_RESET;
        gainDriveControl_r   <= `REG_RESET;
        channelLoTuning_r    <= `REG_RESET;
        dcOffsetCorrection_r <= `REG_RESET;
        intermodTuning_r     <= `REG_RESET;
        lowPower_r           <= 1'b1;
      end else begin
        generalControl_r     <= gcNxt;
        gainDriveControl_r   <= gdNxt;
        channelLoTuning_r    <= `CL_FORCED;
        dcOffsetCorrection_r <= `REG_RESET;
        intermodTuning_r     <= `IM_FORCED;
        lowPower_r           <= 1'b0;
      end
    end else if (dataStrobe) begin
      case (addr_r)
        `ADDR_GENERAL_CONTROL: begin
          generalControl_r <= shift_r;
          lowPower_r       <= 1'b0;
        end
        `ADDR_GAIN_DRIVE:  gainDriveControl_r   <= shift_r;
        `ADDR_CHANNEL_LO:  channelLoTuning_r    <= shift_r;
        `ADDR_DC_OFFSET:   dcOffsetCorrection_r <= shift_r;
        `ADDR_INTERMOD:    intermodTuning_r     <= shift_r;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Offset decode
  // ---------------------------------------------------------------
  wire [9:0] qMv;
  wire [9:0] iMv;
  offset_decode qDec (
    .code       (dcOffsetCorrection_r[7:4]),
    .milliVolts (qMv)
  );
  offset_decode iDec (
    .code       (dcOffsetCorrection_r[3:0]),
    .milliVolts (iMv)
  );
  always @(posedge clk) begin
    if (rst) begin
      qOffsetMv_r <= 10'h000;
      iOffsetMv_r <= 10'h000;
    end else begin
      qOffsetMv_r <= qMv;
      iOffsetMv_r <= iMv;
    end
  end
endmodule // demod_control_registers

// *** dv/demod_ctrl_monitor.sv ***
module demod_ctrl_monitor (
  input logic       clk, rst, serial_disable_n, serial_command_in, sclk, serial_select_n,
  input logic       lowPower_r,
  input logic [7:0] generalControl_r, gainDriveControl_r, channelLoTuning_r,
  input logic [7:0] dcOffsetCorrection_r, intermodTuning_r,
  input logic [9:0] qOffsetMv_r, iOffsetMv_r
);
  timeunit 1ns / 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Six still cycles clear the pin synchroniser
  sequence run_s;
    (!serial_disable_n && serial_command_in && $stable({sclk, serial_select_n}))[*6];
  endsequence
  function automatic logic [9:0] mv(logic [7:0] r, bit hi);
    logic [3:0] c;
    c = hi ? r[7:4] : r[3:0];
    return c[3] ? -(c[2:0] * 10'h03c) : c[2:0] * 10'h03c;
  endfunction
  a_reset_clears: assert property ($fell(rst) |-> lowPower_r &&
    {dcOffsetCorrection_r, intermodTuning_r} == 16'h0000) else $error("reset left state");
  a_divider_pin: assert property (run_s |-> generalControl_r == {!sclk, 7'h12})
    else $error("general control wrong");
  a_gain_pin: assert property (run_s |->
    gainDriveControl_r == (serial_select_n ? 8'h00 : 8'h09)) else $error("gain wrong");
  a_mode_forced: assert property (run_s |-> channelLoTuning_r == 8'h0f && !lowPower_r)
    else $error("mode wrong");
  a_offsets_forced: assert property (run_s |->
    {dcOffsetCorrection_r, intermodTuning_r} == 16'h0000) else $error("tuning not zero");
  a_direct_reset: assert property ((!serial_disable_n && !serial_command_in)[*6] |->
    lowPower_r && {generalControl_r, gainDriveControl_r} == 16'h0000) else $error("no reset");
  a_offset_mv: assert property (!$past(rst) |->
    qOffsetMv_r == mv($past(dcOffsetCorrection_r), 1'b1) &&
    iOffsetMv_r == mv($past(dcOffsetCorrection_r), 1'b0)) else $error("offset mV wrong");
  a_idle_stable: assert property ((serial_disable_n && serial_select_n)[*8] |->
    $stable({dcOffsetCorrection_r, intermodTuning_r})) else $error("write outside frame");
  c_data_write: cover property (!serial_select_n ##1 $changed(intermodTuning_r));
  c_direct_run: cover property (run_s);
  c_reset_cmd: cover property ($fell(lowPower_r) ##[1:1000] $rose(lowPower_r));
endmodule // demod_ctrl_monitor
bind demod_control_registers demod_ctrl_monitor i_mon (.*);

// *** dv/serial_host.sv ***
module serial_host (
  input  logic clk,
  output logic serial_disable_n, serial_command_in, sclk, serial_select_n
);
  timeunit 1ns / 1ps;
  // Clock idles low outside frames
  initial {serial_disable_n, serial_command_in, sclk, serial_select_n} = 4'h9;
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      serial_command_in <= b[i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
    end
  endtask
  task automatic frame(input logic [7:0] a, d, input bit hasData);
    @(posedge clk) serial_select_n <= 1'b0;
    repeat (4) @(posedge clk);
    send(a);
    if (hasData) send(d);
    repeat (8) @(posedge clk);
    serial_select_n <= 1'b1;
    serial_command_in <= ~serial_command_in;
  endtask
  task automatic pins(input logic [3:0] p);
    @(posedge clk) {serial_disable_n, serial_command_in, sclk, serial_select_n} <= p;
    repeat (8) @(posedge clk);
  endtask
endmodule // serial_host

// *** dv/tb_top.sv ***
module tb_top;
  timeunit 1ns / 1ps;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       serial_disable_n, serial_command_in, sclk, serial_select_n, lowPower_r;
  logic [7:0] generalControl_r, gainDriveControl_r, channelLoTuning_r;
  logic [7:0] dcOffsetCorrection_r, intermodTuning_r;
  logic [9:0] qOffsetMv_r, iOffsetMv_r;
  logic [3:0] dpin [3] = '{4'h4, 4'h7, 4'h0};
  int         bad_count = 0;
  int         comparisons = 0;
  always #5 clk = ~clk;
  serial_host i_host (.*);
  demod_control_registers i_dut (.*);
  task automatic check(input logic [9:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch t=%0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Run needs about 1.2k cycles; the limit leaves wide slack
  initial begin
    #100us;
    bad_count++;
    results();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    check(lowPower_r, 1'b1);
    i_host.frame(8'h1f, 8'h8f, 1'b1);
    check(dcOffsetCorrection_r, 8'h8f);
    check(iOffsetMv_r, 10'h25c);
    check(qOffsetMv_r, 10'h000);
    i_host.frame(8'h1f, 8'h70, 1'b1);
    check(qOffsetMv_r, 10'h1a4);
    i_host.frame(8'h2f, 8'hfc, 1'b1);
    i_host.frame(8'h2e, 8'h55, 1'b1);
    check(intermodTuning_r, 8'hfc);
    i_host.frame(8'h1b, 8'h92, 1'b1);
    check(generalControl_r, 8'h92);
    check(lowPower_r, 1'b0);
    i_host.frame(8'h1c, 8'h49, 1'b1);
    check(gainDriveControl_r, 8'h49);
    i_host.frame(8'h1d, 8'h0f, 1'b1);
    check(channelLoTuning_r, 8'h0f);
    i_host.frame(8'h1a, 8'h33, 1'b0);
    check({2'b00, dcOffsetCorrection_r | intermodTuning_r}, 10'h000);
    check(generalControl_r, 8'h00);
    check(gainDriveControl_r, 8'h00);
    check(channelLoTuning_r, 8'h00);
    check(lowPower_r, 1'b1);
    i_host.frame(8'h1f, 8'h33, 1'b1);
    foreach (dpin[k]) begin
      i_host.pins(dpin[k]);
      check(generalControl_r, dpin[k][2] ? {~dpin[k][1], 7'h12} : 8'h00);
      check(gainDriveControl_r, dpin[k][2] && !dpin[k][0] ? 8'h09 : 8'h00);
      check(channelLoTuning_r, dpin[k][2] ? 8'h0f : 8'h00);
      check(dcOffsetCorrection_r, 8'h00);
      check(lowPower_r, !dpin[k][2]);
    end
    results();
  end
endmodule // tb_top
